//--- hw/commutation_pkg.sv
// constants, field layouts and carrier types for the commutation and gate-control block
// assumes a single 25 MHz logic clock and an active-low asynchronous reset
package commutation_pkg;

	// clock and timing
	localparam int CLK_HZ = 25_000_000;
	localparam int PEAK_US = 15;
	localparam int PEAK_CYCLES = (PEAK_US * (CLK_HZ / 1_000_000));
	localparam int BLANK_NS = 2000;
	localparam int BLANK_CYCLES = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int HALL_MULT = 960;
	localparam int STEP_TICKS = HALL_MULT / 6;

	// register map, byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_GATES = 4'h8;

	// control field positions and reset value
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_SINGLE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;

	// status field positions
	localparam int ST_HALL_LSB = 0;
	localparam int ST_LOCK_BIT = 3;
	localparam int ST_UV_BIT = 4;
	localparam int ST_BRAKE_BIT = 5;
	localparam int ST_ILLEGAL_BIT = 6;
	localparam int ST_FAULT_PIN_BIT = 7;
	localparam int ST_MODE_LSB = 8;
	localparam int ST_TRIP_LSB = 12;

	// commutation modes, one-hot
	typedef enum logic [3:0] {
		MODE_OFF = 4'h1,
		MODE_TABLE = 4'h2,
		MODE_SINGLE = 4'h4,
		MODE_BRAKE = 4'h8
	} mode_t;

	// per-phase gate commands, bit 0 = u, 1 = v, 2 = w
	typedef struct packed {
		logic [2:0] top;
		logic [2:0] bottom;
	} gate_t;

	// synchronised pin inputs
	typedef struct packed {
		logic [2:0] hall;
		logic dir;
		logic brake;
		logic run_request_low;
		logic climit;
		logic supply_undervoltage;
	} pins_t;

endpackage

//--- hw/single_hall_timer.sv
// single-hall commutation timer and constant-speed detector
// assumes a filtered phase-u hall level on the same clock as the module
module single_hall_timer import commutation_pkg::*; #(
	parameter int PER_W = 24,
	parameter int LOCK_MATCHES = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hall_u_i,
	input wire logic dir_i,
	input wire logic run_i,
	output logic [2:0] state_o,
	output logic locked_o
);

	if (PER_W < 12 || LOCK_MATCHES < 1 || LOCK_MATCHES > 15) begin : g_bad_param
		$error("single_hall_timer: unsupported parameter");
	end

	logic hall_q_r, hall_q_nxt;
	logic [PER_W-1:0] per_r, per_nxt, last_r, last_nxt;
	logic [PER_W:0] acc_r, acc_nxt;
	logic [7:0] ticks_r, ticks_nxt;
	logic [1:0] steps_r, steps_nxt;
	logic [3:0] match_r, match_nxt;
	logic [2:0] state_r, state_nxt;
	logic locked_r, locked_nxt;

	// period measure, 960x tick generator, state stepping and lock detector
	always_comb begin
		logic [PER_W-1:0] diff;
		logic rise;
		logic fall;
		diff = '0;
		rise = hall_u_i & ~hall_q_r;
		fall = ~hall_u_i & hall_q_r;
		hall_q_nxt = hall_u_i;
		per_nxt = (&per_r) ? per_r : per_r + 1'b1;
		last_nxt = last_r;
		acc_nxt = acc_r + (PER_W+1)'(HALL_MULT);
		ticks_nxt = ticks_r;
		steps_nxt = steps_r;
		match_nxt = match_r;
		state_nxt = state_r;
		locked_nxt = locked_r;
		// one tick each time the accumulator passes one period: 960 ticks per hall cycle
		if (last_r != '0 && acc_nxt >= {1'b0, last_r}) begin
			acc_nxt = acc_nxt - {1'b0, last_r};
			if (ticks_r == 8'(STEP_TICKS - 1)) begin
				ticks_nxt = '0;
				if (steps_r != 2'h2 && state_r != 3'h0) begin
					steps_nxt = steps_r + 1'b1;
					state_nxt = (state_r == 3'h6) ? 3'h1 : state_r + 1'b1;
				end
			end else begin
				ticks_nxt = ticks_r + 1'b1;
			end
		end
		// phase-u edges realign the state: rising enters 4 or 1 depending on direction
		if (rise || fall) begin
			acc_nxt = '0;
			ticks_nxt = '0;
			steps_nxt = '0;
			state_nxt = (rise == dir_i) ? 3'h4 : 3'h1;
		end
		if (rise) begin
			per_nxt = '0;
			last_nxt = per_r;
			diff = (per_r > last_r) ? per_r - last_r : last_r - per_r;
			if (diff <= (last_r >> 4) && last_r != '0) begin
				match_nxt = (match_r == 4'(LOCK_MATCHES)) ? match_r : match_r + 1'b1;
			end else begin
				match_nxt = '0;
			end
		end
		locked_nxt = (match_nxt == 4'(LOCK_MATCHES));
		// sudden slow-down, stall or stop drops the lock at once
		if (!run_i || &per_r || (last_r != '0 && per_r > last_r + (last_r >> 3))) begin
			match_nxt = '0;
			locked_nxt = 1'b0;
		end
	end

	// registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hall_q_r <= 1'b0;
			per_r <= '0;
			last_r <= '0;
			acc_r <= '0;
			ticks_r <= '0;
			steps_r <= '0;
			match_r <= '0;
			state_r <= 3'h0;
			locked_r <= 1'b0;
		end else begin
			hall_q_r <= hall_q_nxt;
			per_r <= per_nxt;
			last_r <= last_nxt;
			acc_r <= acc_nxt;
			ticks_r <= ticks_nxt;
			steps_r <= steps_nxt;
			match_r <= match_nxt;
			state_r <= state_nxt;
			locked_r <= locked_nxt;
		end
	end

	assign state_o = state_r;
	assign locked_o = locked_r;

endmodule

//--- hw/bldc_commutation_gate_control.sv
// top of the commutation and gate-control logic for a sensored three-phase pre-driver
// assumes hall comparators, brake, direction, run request, current-limit and undervoltage
// detectors arrive asynchronously; duty signals come from a pwm generator on clk_i
module bldc_commutation_gate_control import commutation_pkg::*; #(
	parameter int PER_W = 24,
	parameter int LOCK_MATCHES = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// asynchronous pin inputs
	input wire logic [2:0] hall_i,
	input wire logic dir_i,
	input wire logic brake_i,
	input wire logic run_request_low_i,
	input wire logic climit_i,
	input wire logic supply_undervoltage_i,
	// duty signals from the pwm generator
	input wire logic phase_u_duty_i,
	input wire logic phase_v_duty_i,
	input wire logic phase_w_duty_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// gate commands
	output logic phase_u_top_gate_out_o,
	output logic phase_u_bottom_gate_out_o,
	output logic phase_v_top_gate_out_o,
	output logic phase_v_bottom_gate_out_o,
	output logic phase_w_top_gate_out_o,
	output logic phase_w_bottom_gate_out_o,
	output logic [5:0] peak_drive_o,
	// supplies and status pins
	output logic charge_pump_rail_en_o,
	output logic five_volt_regulator_en_o,
	output logic switched_supply_out_on_o,
	output logic speed_locked_o,
	input wire logic fault_out_low_i,
	output logic fault_out_low_o,
	output logic fault_out_low_oe_o
);

	if (PEAK_CYCLES < 1 || BLANK_CYCLES < 1 ||
		PEAK_CYCLES > 511 || BLANK_CYCLES > 255) begin : g_bad_timing
		$error("bldc_commutation_gate_control: timing constants out of range");
	end

	// maps a hall pattern to a state 1..6, or 0 for the two illegal patterns
	function automatic logic [2:0] hall_to_state(input logic [2:0] h, input logic d);
		logic [2:0] p;
		// the pin vector holds u in bit 0, the patterns below read u,v,w from the top bit
		p = d ? {h[0], h[1], h[2]} : ~{h[0], h[1], h[2]};
		unique case (p)
			3'b001: hall_to_state = 3'h1;
			3'b011: hall_to_state = 3'h2;
			3'b010: hall_to_state = 3'h3;
			3'b110: hall_to_state = 3'h4;
			3'b100: hall_to_state = 3'h5;
			3'b101: hall_to_state = 3'h6;
			default: hall_to_state = 3'h0;
		endcase
	endfunction

	// phase enables for a state: top = modulated phase, bottom = phase held on
	function automatic gate_t state_to_enable(input logic [2:0] s);
		gate_t g;
		g.top = 3'h0;
		g.bottom = 3'h0;
		unique case (s)
			3'h1: g = '{top: 3'b010, bottom: 3'b100};
			3'h2: g = '{top: 3'b001, bottom: 3'b100};
			3'h3: g = '{top: 3'b001, bottom: 3'b010};
			3'h4: g = '{top: 3'b100, bottom: 3'b010};
			3'h5: g = '{top: 3'b100, bottom: 3'b001};
			3'h6: g = '{top: 3'b010, bottom: 3'b001};
			default: g = '{top: 3'b000, bottom: 3'b000};
		endcase
		return g;
	endfunction

	// three-stage synchronisers, filtered level follows once stages two and three agree
	pins_t s1_r, s2_r, s3_r, pin_r, pin_nxt;

	always_comb begin
		pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r <= '{run_request_low: 1'b1, default: 1'b0};
			s2_r <= '{run_request_low: 1'b1, default: 1'b0};
			s3_r <= '{run_request_low: 1'b1, default: 1'b0};
			pin_r <= '{run_request_low: 1'b1, default: 1'b0};
		end else begin
			s1_r <= '{hall_i, dir_i, brake_i, run_request_low_i, climit_i,
				supply_undervoltage_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= pin_nxt;
		end
	end

	// single-hall timer and speed lock
	logic [2:0] single_state;
	logic locked;

	single_hall_timer #(
		.PER_W(PER_W),
		.LOCK_MATCHES(LOCK_MATCHES)
	) u_single_hall_timer (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.hall_u_i(pin_r.hall[0]),
		.dir_i(pin_r.dir),
		.run_i(~pin_r.run_request_low),
		.state_o(single_state),
		.locked_o(locked)
	);

	// control register and read data
	logic [1:0] ctrl_r, ctrl_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	mode_t mode_r, mode_nxt;
	gate_t gate_r, gate_nxt;
	logic [2:0] trip_r, trip_nxt;
	logic illegal;

	assign illegal = (hall_to_state(pin_r.hall, pin_r.dir) == 3'h0);

	always_comb begin
		ctrl_nxt = ctrl_r;
		rdata_nxt = '0;
		if (reg_write_i && reg_addr_i == OFS_CTRL) begin
			ctrl_nxt = reg_wdata_i[1:0];
		end
		if (reg_read_i) begin
			unique case (reg_addr_i)
				OFS_CTRL: rdata_nxt[1:0] = ctrl_r;
				OFS_STATUS: begin
					rdata_nxt[ST_HALL_LSB +: 3] = pin_r.hall;
					rdata_nxt[ST_LOCK_BIT] = locked;
					rdata_nxt[ST_UV_BIT] = pin_r.supply_undervoltage;
					rdata_nxt[ST_BRAKE_BIT] = pin_r.brake;
					rdata_nxt[ST_ILLEGAL_BIT] = illegal;
					rdata_nxt[ST_FAULT_PIN_BIT] = fault_out_low_i;
					rdata_nxt[ST_MODE_LSB +: 4] = mode_r;
					rdata_nxt[ST_TRIP_LSB +: 3] = trip_r;
				end
				OFS_GATES: rdata_nxt[5:0] = gate_r;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_r <= CTRL_RESET;
			rdata_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// mode selection: standby and undervoltage first, then brake, then lock
	always_comb begin
		if (pin_r.run_request_low || pin_r.supply_undervoltage) begin
			mode_nxt = MODE_OFF;
		end else if (pin_r.brake) begin
			mode_nxt = MODE_BRAKE;
		end else if (locked && ctrl_r[CTRL_SINGLE_BIT]) begin
			mode_nxt = MODE_SINGLE;
		end else begin
			mode_nxt = MODE_TABLE;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r <= MODE_OFF;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// pwm cycle start and blanking per phase
	logic [2:0] duty, duty_q_r, cyc_start;
	logic [7:0] blank_r [3];
	logic [7:0] blank_nxt [3];

	assign duty = {phase_w_duty_i, phase_v_duty_i, phase_u_duty_i};
	assign cyc_start = duty & ~duty_q_r;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (cyc_start[i]) begin
				blank_nxt[i] = 8'(BLANK_CYCLES);
			end else begin
				blank_nxt[i] = (blank_r[i] != 8'h00) ? blank_r[i] - 8'h01 : 8'h00;
			end
		end
	end

	// current-limit trip latches, a fresh trip wins over the cycle-start clear
	logic [2:0] trip_set;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			trip_set[i] = pin_r.climit && blank_r[i] == 8'h00 && gate_r.top[i];
		end
		trip_nxt = (trip_r & ~cyc_start) | trip_set;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			duty_q_r <= 3'h0;
			trip_r <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				blank_r[i] <= 8'h00;
			end
		end else begin
			duty_q_r <= duty;
			trip_r <= trip_nxt;
			for (int i = 0; i < 3; i++) begin
				blank_r[i] <= blank_nxt[i];
			end
		end
	end

	// gate equations from the selected commutation state
	always_comb begin
		gate_t en;
		logic [2:0] st;
		logic [2:0] hi;
		st = (mode_r == MODE_SINGLE) ? single_state : hall_to_state(pin_r.hall, pin_r.dir);
		en = state_to_enable(st);
		hi = duty & en.top & ~trip_r & ~trip_set;
		gate_nxt.top = 3'h0;
		gate_nxt.bottom = 3'h0;
		unique case (mode_r)
			MODE_OFF: gate_nxt = '0;
			MODE_BRAKE: begin
				gate_nxt.top = 3'h0;
				gate_nxt.bottom = 3'h7;
			end
			MODE_TABLE, MODE_SINGLE: begin
				gate_nxt.top = hi;
				// synchronous mode fills the off time of the modulated phase, trips included
				gate_nxt.bottom = en.bottom | ({3{ctrl_r[CTRL_SYNC_BIT]}} & en.top & ~hi);
			end
			default: gate_nxt = '0;
		endcase
		if (illegal) begin
			gate_nxt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gate_r <= '0;
		end else begin
			gate_r <= gate_nxt;
		end
	end

	// peak drive window restarts on every change of each gate command
	logic [5:0] gate_flat, gate_prev_r, peak_r, peak_nxt;
	logic [8:0] peak_cnt_r [6];
	logic [8:0] peak_cnt_nxt [6];

	assign gate_flat = gate_r;

	for (genvar g = 0; g < 6; g++) begin : g_peak
		always_comb begin
			if (gate_flat[g] != gate_prev_r[g]) begin
				peak_cnt_nxt[g] = 9'(PEAK_CYCLES - 1);
				peak_nxt[g] = 1'b1;
			end else if (peak_cnt_r[g] != 9'h000) begin
				peak_cnt_nxt[g] = peak_cnt_r[g] - 9'h001;
				peak_nxt[g] = 1'b1;
			end else begin
				peak_cnt_nxt[g] = 9'h000;
				peak_nxt[g] = 1'b0;
			end
		end

		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				peak_cnt_r[g] <= 9'h000;
				peak_r[g] <= 1'b0;
				gate_prev_r[g] <= 1'b0;
			end else begin
				peak_cnt_r[g] <= peak_cnt_nxt[g];
				peak_r[g] <= peak_nxt[g];
				gate_prev_r[g] <= gate_flat[g];
			end
		end
	end

	// supplies, lock and fault pin
	logic supplies_r, supplies_nxt, locked_r, fault_r, fault_nxt;

	always_comb begin
		supplies_nxt = ~pin_r.run_request_low;
		fault_nxt = pin_r.supply_undervoltage;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			supplies_r <= 1'b0;
			locked_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			supplies_r <= supplies_nxt;
			locked_r <= locked;
			fault_r <= fault_nxt;
		end
	end

	// outputs
	assign reg_rdata_o = rdata_r;
	assign phase_u_top_gate_out_o = gate_r.top[0];
	assign phase_v_top_gate_out_o = gate_r.top[1];
	assign phase_w_top_gate_out_o = gate_r.top[2];
	assign phase_u_bottom_gate_out_o = gate_r.bottom[0];
	assign phase_v_bottom_gate_out_o = gate_r.bottom[1];
	assign phase_w_bottom_gate_out_o = gate_r.bottom[2];
	assign peak_drive_o = peak_r;
	assign charge_pump_rail_en_o = supplies_r;
	assign five_volt_regulator_en_o = supplies_r;
	assign switched_supply_out_on_o = supplies_r;
	assign speed_locked_o = locked_r;
	assign fault_out_low_o = 1'b0; // open drain: only ever pulls low
	assign fault_out_low_oe_o = fault_r;

endmodule

//--- verif/motor_side_model.sv
// far side: hall sensors for a commanded rotor step, plus the pulled-up fault wire
// assumes steps 1 to 6 are legal positions; 0 and 7 give the all-low and all-high faults
module motor_side_model (
	// rotor step and direction
	input wire logic [2:0] step_i,
	input wire logic dir_i,
	// fault pull-down from the block
	input wire logic fault_oe_i,
	// sensor levels and wire level
	output logic [2:0] hall_o,
	output logic fault_wire_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] UVW_OF [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h7};
	logic [2:0] uvw;
	logic legal;

	// sensor levels u,v,w per step, complemented for the reverse sequence
	always_comb begin
		legal = (step_i != 3'h0) && (step_i != 3'h7);
		uvw = (legal && !dir_i) ? ~UVW_OF[step_i] : UVW_OF[step_i];
		hall_o = {uvw[0], uvw[1], uvw[2]};
	end

	// open-drain line with a pull-up: high unless pulled
	assign fault_wire_o = fault_oe_i ? 1'b0 : 1'b1;
endmodule

//--- verif/commutation_props.sv
// checker: gate, supply and fault relations seen at the block's ports
// assumes a bind to the top module, one clock and an active-low asynchronous reset
module commutation_props import commutation_pkg::*; #(
	parameter int PER_W = 24,
	parameter int LOCK_MATCHES = 4
) (
	// clock, reset and pins
	input wire logic clk_i, nrst_i,
	input wire logic [2:0] hall_i,
	input wire logic dir_i, brake_i, run_request_low_i, climit_i, supply_undervoltage_i,
	input wire logic phase_u_duty_i, phase_v_duty_i, phase_w_duty_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i, reg_read_i,
	input wire logic [31:0] reg_rdata_o,
	// gates, supplies and fault
	input wire logic phase_u_top_gate_out_o, phase_u_bottom_gate_out_o,
	input wire logic phase_v_top_gate_out_o, phase_v_bottom_gate_out_o,
	input wire logic phase_w_top_gate_out_o, phase_w_bottom_gate_out_o,
	input wire logic [5:0] peak_drive_o,
	input wire logic charge_pump_rail_en_o, five_volt_regulator_en_o, switched_supply_out_on_o,
	input wire logic speed_locked_o, fault_out_low_i, fault_out_low_o, fault_out_low_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic [2:0] tops, bots, duties;
	logic [2:0] sups;

	// gathered gate and duty vectors with bit 0 = u, and the supply vector with bit 0 = switched supply
	assign tops = {phase_w_top_gate_out_o, phase_v_top_gate_out_o, phase_u_top_gate_out_o};
	assign bots = {phase_w_bottom_gate_out_o, phase_v_bottom_gate_out_o, phase_u_bottom_gate_out_o};
	assign duties = {phase_w_duty_i, phase_v_duty_i, phase_u_duty_i};
	assign sups = {charge_pump_rail_en_o, five_volt_regulator_en_o, switched_supply_out_on_o};

	sequence s_uv_on; supply_undervoltage_i [*8]; endsequence
	sequence s_brake_calm;
		(brake_i && !run_request_low_i && !supply_undervoltage_i && hall_i != 3'h0
			&& hall_i != 3'h7) [*8];
	endsequence

	property p_uv_fault; s_uv_on |-> fault_out_low_oe_o && (tops | bots) == 3'h0; endproperty
	a_uv_fault: assert property (p_uv_fault)
		else $error("undervoltage held without fault or gate cut");
	property p_uv_clear; !supply_undervoltage_i [*8] |-> !fault_out_low_oe_o; endproperty
	a_uv_clear: assert property (p_uv_clear)
		else $error("fault line still pulled after undervoltage cleared");
	property p_run_on; !run_request_low_i [*8] |-> sups == 3'h7; endproperty
	a_run_on: assert property (p_run_on)
		else $error("supplies off while running");
	property p_run_off; run_request_low_i [*8] |-> sups == 3'h0; endproperty
	a_run_off: assert property (p_run_off)
		else $error("supplies on in standby");
	property p_illegal; (hall_i == 3'h0 || hall_i == 3'h7) [*8] |-> (tops | bots) == 3'h0;
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("gates driven with illegal hall code");
	property p_brake; s_brake_calm |-> tops == 3'h0 && bots == 3'h7; endproperty
	a_brake: assert property (p_brake)
		else $error("brake gates wrong");
	property p_duty_gate; (tops & ~$past(duties)) == 3'h0; endproperty
	a_duty_gate: assert property (p_duty_gate)
		else $error("top gate on without duty");
	property p_no_overlap; (tops & bots) == 3'h0; endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("top and bottom gate on together");
	// peak bits follow the gate carrier: bottoms in 2:0, tops in 5:3
	property p_peak; $changed(phase_u_top_gate_out_o) |=> peak_drive_o[3] [*8]; endproperty
	a_peak: assert property (p_peak)
		else $error("peak drive missing after gate change");
endmodule

bind bldc_commutation_gate_control commutation_props #(
	.PER_W(PER_W),
	.LOCK_MATCHES(LOCK_MATCHES)
) props_i (.*);

//--- verif/bldc_commutation_gate_control_tb.sv
// self-checking bench for the commutation and gate-control block
// assumes the motor-side model for hall levels and the fault wire pull-up
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
	end \
end

module bldc_commutation_gate_control_tb import commutation_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, nrst_i, dir_i, brake_i, run_request_low_i, climit_i, supply_undervoltage_i;
	logic [2:0] step, hall_i, duty, tops, bots;
	logic [3:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, rd;
	logic reg_write_i, reg_read_i, fault_wire, fault_o, fault_oe, locked;
	logic [5:0] peak;
	logic cp_en, reg_en, sw_on;
	int bad_count, samples_checked;
	int pw_of [7] = '{0, 1, 0, 0, 2, 2, 1};
	int lo_of [7] = '{0, 2, 2, 1, 1, 0, 0};

	// block under test, short lock count for simulation
	bldc_commutation_gate_control #(.LOCK_MATCHES(2)) uut (
		.clk_i(clk_i), .nrst_i(nrst_i), .hall_i(hall_i), .dir_i(dir_i), .brake_i(brake_i),
		.run_request_low_i(run_request_low_i), .climit_i(climit_i),
		.supply_undervoltage_i(supply_undervoltage_i), .phase_u_duty_i(duty[0]),
		.phase_v_duty_i(duty[1]), .phase_w_duty_i(duty[2]), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .phase_u_top_gate_out_o(tops[0]),
		.phase_u_bottom_gate_out_o(bots[0]), .phase_v_top_gate_out_o(tops[1]),
		.phase_v_bottom_gate_out_o(bots[1]), .phase_w_top_gate_out_o(tops[2]),
		.phase_w_bottom_gate_out_o(bots[2]), .peak_drive_o(peak),
		.charge_pump_rail_en_o(cp_en), .five_volt_regulator_en_o(reg_en),
		.switched_supply_out_on_o(sw_on), .speed_locked_o(locked),
		.fault_out_low_i(fault_wire), .fault_out_low_o(fault_o), .fault_out_low_oe_o(fault_oe)
	);

	// hall sensors and fault wire
	motor_side_model motor_i (.step_i(step), .dir_i(dir_i), .fault_oe_i(fault_oe),
		.hall_o(hall_i), .fault_wire_o(fault_wire));

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic look;
		@(negedge clk_i);
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_read_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask

	// six table states, duty high then low
	task automatic walk(input logic d, input logic sync);
		logic [2:0] pw_m, lo_m;
		for (int s = 1; s <= 6; s++) begin
			pw_m = 3'(1 << pw_of[s]);
			lo_m = 3'(1 << lo_of[s]);
			@(posedge clk_i);
			step <= 3'(s);
			dir_i <= d;
			duty <= 3'h7;
			tick(8);
			look();
			`CHK({bots, tops}, {lo_m, pw_m});
			@(posedge clk_i);
			duty <= 3'h0;
			tick(3);
			look();
			`CHK({bots, tops}, {lo_m | (sync ? pw_m : 3'h0), 3'h0});
		end
	endtask

	task automatic conclude;
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// hang guard, well past the expected run
	initial begin
		tick(60000);
		bad_count++;
		conclude();
	end

	initial begin
		{nrst_i, brake_i, climit_i, supply_undervoltage_i, reg_write_i, reg_read_i} = 6'h0;
		{step, dir_i, run_request_low_i, duty, reg_addr_i, reg_wdata_i} = {3'h1, 2'h3, 39'h0};
		tick(2);
		nrst_i <= 1'b1;
		rd_reg(OFS_CTRL, rd);
		`CHK(rd[1:0], CTRL_RESET);
		rd_reg(4'hC, rd);
		`CHK(rd, 32'h0);
		look();
		`CHK({cp_en, reg_en, sw_on, bots, tops}, 9'h0);
		@(posedge clk_i);
		run_request_low_i <= 1'b0;
		tick(8);
		look();
		`CHK({cp_en, reg_en, sw_on}, 3'h7);
		for (int m = 0; m < 4; m++) begin
			wr_reg(OFS_CTRL, 32'(m % 2));
			walk(m < 2, m % 2 == 1);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			step <= 3'(k * 7);
			duty <= 3'h7;
			tick(8);
			look();
			`CHK({bots, tops}, 6'h0);
		end
		@(posedge clk_i);
		step <= 3'h2;
		brake_i <= 1'b1;
		tick(8);
		look();
		`CHK({bots, tops}, {3'h7, 3'h0});
		rd_reg(OFS_STATUS, rd);
		`CHK(rd[ST_BRAKE_BIT], 1'b1);
		@(posedge clk_i);
		brake_i <= 1'b0;
		supply_undervoltage_i <= 1'b1;
		tick(8);
		look();
		`CHK({fault_o, fault_wire, bots, tops}, 8'h0);
		@(posedge clk_i);
		supply_undervoltage_i <= 1'b0;
		tick(8);
		look();
		`CHK({fault_wire, bots, tops}, {1'b1, 3'h4, 3'h1});
		wr_reg(OFS_CTRL, 32'h1);
		duty <= 3'h0;
		tick(4);
		duty <= 3'h7;
		tick(10);
		climit_i <= 1'b1;
		tick(10);
		look();
		`CHK(tops[0], 1'b1);
		tick(BLANK_CYCLES);
		look();
		`CHK({bots[0], tops[0]}, 2'h2);
		@(posedge clk_i);
		climit_i <= 1'b0;
		tick(10);
		look();
		`CHK(tops[0], 1'b0);
		@(posedge clk_i);
		duty <= 3'h0;
		tick(2);
		duty <= 3'h7;
		tick(4);
		look();
		`CHK({peak[3], tops[0]}, 2'h3);
		tick(PEAK_CYCLES - 20);
		look();
		`CHK(peak[0], 1'b1);
		tick(30);
		look();
		`CHK(peak, 6'h0);
		wr_reg(OFS_CTRL, 32'h3);
		for (int k = 0; k < 48; k++) begin
			step <= 3'(k % 6 + 1);
			tick(400);
		end
		look();
		`CHK(locked, 1'b1);
		rd_reg(OFS_STATUS, rd);
		`CHK(rd[ST_MODE_LSB +: 4], MODE_SINGLE);
		@(posedge clk_i);
		run_request_low_i <= 1'b1;
		tick(8);
		look();
		`CHK(locked, 1'b0);
		@(posedge clk_i);
		run_request_low_i <= 1'b0;
		tick(8);
		rd_reg(OFS_STATUS, rd);
		`CHK(rd[ST_MODE_LSB +: 4], MODE_TABLE);
		conclude();
	end
endmodule
